//--- dtec_defs.vh
`ifndef DTEC_DEFS_VH
`define DTEC_DEFS_VH

// ============================================================
// Register offsets (byte addresses on the 8-bit register port)
// ============================================================
`define DTEC_OFS_RUN_FLAG    8'h88
`define DTEC_OFS_MODE_CTRL   8'h89
`define DTEC_OFS_LOW0        8'h8A
`define DTEC_OFS_LOW1        8'h8B
`define DTEC_OFS_HIGH0       8'h8C
`define DTEC_OFS_HIGH1       8'h8D
`define DTEC_OFS_TOGGLE_EN   8'h8E
`define DTEC_OFS_IRQ_STATUS  8'h90
`define DTEC_OFS_IRQ_MASK    8'h91

// ============================================================
// Mode control field positions
// ============================================================
`define DTEC_MC_GATE1        7
`define DTEC_MC_SRC1         6
`define DTEC_MC_MODE1_HI     5
`define DTEC_MC_MODE1_LO     4
`define DTEC_MC_GATE0        3
`define DTEC_MC_SRC0         2
`define DTEC_MC_MODE0_HI     1
`define DTEC_MC_MODE0_LO     0

// ============================================================
// Run and flag register field positions
// ============================================================
`define DTEC_RF_FLAG1        7
`define DTEC_RF_RUN1         6
`define DTEC_RF_FLAG0        5
`define DTEC_RF_RUN0         4

// ============================================================
// Toggle enable and interrupt field positions
// ============================================================
`define DTEC_TG_EN0          0
`define DTEC_TG_EN1          1
`define DTEC_IRQ_OVF0        0
`define DTEC_IRQ_OVF1        1

// ============================================================
// Operating modes
// ============================================================
`define DTEC_MODE_13BIT      2'h0
`define DTEC_MODE_16BIT      2'h1
`define DTEC_MODE_RELOAD     2'h2
`define DTEC_MODE_SPLIT      2'h3

// ============================================================
// Reset values and timing
// ============================================================
`define DTEC_RST_BYTE        8'h00
`define DTEC_RST_IRQ         2'h0
`define DTEC_MCYCLE_CLKS     3'h6
`define DTEC_MCYCLE_LAST     3'h5

`endif

//--- dtec_mcycle.v
`timescale 1ns/10ps
`include "dtec_defs.vh"

// ============================================================
// Machine cycle strobe: one pulse every six clocks
// ============================================================
module dtec_mcycle (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst_n,
  // Machine cycle strobe
  output wire o_tick
);

  reg [2:0] phase_q;
  reg [2:0] phase_d;

  // Count the six clock phases of a machine cycle.
  always @* begin
    if (phase_q == `DTEC_MCYCLE_LAST) begin
      phase_d = 3'h0;
    end else begin
      phase_d = phase_q + 3'h1;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      phase_q <= 3'h0;
    end else begin
      phase_q <= phase_d;
    end
  end

  // The strobe marks the last phase, so the first tick comes six clocks after reset.
  assign o_tick = (phase_q == `DTEC_MCYCLE_LAST);

endmodule

//--- dtec_count_pin.v
`timescale 1ns/10ps
`include "dtec_defs.vh"

// ============================================================
// Count pin sampler and overflow toggle driver, one per timer
// ============================================================
module dtec_count_pin (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst_n,
  // Machine cycle strobe and overflow event
  input  wire i_tick,
  input  wire i_overflow,
  input  wire i_toggle_en,
  // Pin
  input  wire i_pin,
  output wire o_pin,
  output wire o_pin_oe,
  // Detected falling edge, held for one machine cycle
  output wire o_fall
);

  reg sample_q;
  reg fall_q;
  reg level_q;

  // Sample once per machine cycle; a high then a low sample is an edge.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      sample_q <= 1'b0;
      fall_q   <= 1'b0;
    end else if (i_tick) begin
      sample_q <= i_pin;
      fall_q   <= sample_q & ~i_pin;
    end
  end

  // Toggle output idles high, so the first overflow drives it low.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      level_q <= 1'b1;
    end else if (!i_toggle_en) begin
      level_q <= 1'b1;
    end else if (i_overflow) begin
      level_q <= ~level_q;
    end
  end

  assign o_fall   = fall_q;
  assign o_pin    = level_q;
  assign o_pin_oe = i_toggle_en;

endmodule

//--- dtec_timer.v
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "dtec_defs.vh"

// Notes on behaviour
// - Timer function counts one per machine cycle of six clocks.
// - Counter function samples the pin each machine cycle, counts high-then-low.
// - The count shows in the machine cycle after the edge was detected.
// - Edge recognition takes two machine cycles, twelve clocks.
// - Source bit clear selects machine cycles, set selects the count pin.
// - Gate set: count only while gate pin high and run set; split mode: high byte ungated, second timer needs no run bit.
// - Two mode bits per timer select one of four modes.
// - Modes zero to two equal for both timers; mode three differs.
// - Optional toggle of each count pin on that timer's overflow.
// - Mode zero: 13-bit count, low five bits act as prescaler.
// - Mode one: full sixteen-bit cascade, no prescaler.
// - Mode two: low byte counts, reloads from high byte on overflow.
// - Mode three: second timer stops; first splits into two bytes.
module dtec_timer (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst_n,
  // Register port
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // First timer pins
  input  wire       i_first_count_pin,
  output wire       o_first_count_pin,
  output wire       o_first_count_pin_oe,
  input  wire       i_first_gate_pin,
  // Second timer pins
  input  wire       i_second_count_pin,
  output wire       o_second_count_pin,
  output wire       o_second_count_pin_oe,
  input  wire       i_second_gate_pin,
  // Interrupt
  output wire       o_irq
);

  // ============================================================
  // Register state
  // ============================================================
  reg  [7:0] timer_mode_control_q;
  reg  [7:0] low0_q;
  reg  [7:0] low1_q;
  reg  [7:0] high0_q;
  reg  [7:0] high1_q;
  reg        first_timer_run_q;
  reg        second_timer_run_q;
  reg        first_timer_overflow_flag_q;
  reg        second_timer_overflow_flag_q;
  reg  [1:0] toggle_en_q;
  reg  [1:0] irq_status_q;
  reg  [1:0] irq_mask_q;

  reg  [7:0] low0_d;
  reg  [7:0] low1_d;
  reg  [7:0] high0_d;
  reg  [7:0] high1_d;
  reg        ovf0;
  reg        ovf1;
  reg        ovf_split_high;

  wire       tick;
  wire       fall0;
  wire       fall1;

  // ============================================================
  // Decoded mode control fields
  // ============================================================
  // mode field split
  wire [1:0] mode0 = {timer_mode_control_q[`DTEC_MC_MODE0_HI],
                      timer_mode_control_q[`DTEC_MC_MODE0_LO]};
  wire [1:0] mode1 = {timer_mode_control_q[`DTEC_MC_MODE1_HI],
                      timer_mode_control_q[`DTEC_MC_MODE1_LO]};
  wire       gate0 = timer_mode_control_q[`DTEC_MC_GATE0];
  wire       gate1 = timer_mode_control_q[`DTEC_MC_GATE1];
  wire       src0  = timer_mode_control_q[`DTEC_MC_SRC0];
  wire       src1  = timer_mode_control_q[`DTEC_MC_SRC1];
  wire       split = (mode0 == `DTEC_MODE_SPLIT);

  // ============================================================
  // Machine cycle and pin handling
  // ============================================================
  // machine cycle strobe
  dtec_mcycle u_mcycle (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_tick  (tick)
  );

  dtec_count_pin u_pin0 (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_tick      (tick),
    .i_overflow  (ovf0),
    .i_toggle_en (toggle_en_q[`DTEC_TG_EN0]),
    .i_pin       (i_first_count_pin),
    .o_pin       (o_first_count_pin),
    .o_pin_oe    (o_first_count_pin_oe),
    .o_fall      (fall0)
  );

  dtec_count_pin u_pin1 (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_tick      (tick),
    .i_overflow  (ovf1),
    .i_toggle_en (toggle_en_q[`DTEC_TG_EN1]),
    .i_pin       (i_second_count_pin),
    .o_pin       (o_second_count_pin),
    .o_pin_oe    (o_second_count_pin_oe),
    .o_fall      (fall1)
  );

  // ============================================================
  // Count enables
  // ============================================================
  // source select; an edge is counted at the tick after detection.
  wire pulse0 = src0 ? fall0 : 1'b1;
  wire pulse1 = src1 ? fall1 : 1'b1;

  // gating by run bit and gate pin
  wire open0 = first_timer_run_q & (~gate0 | i_first_gate_pin);
  // While the first timer is split its high byte borrows the second run bit, so the
  // second timer then ignores its run bit, counts under its gate, and is switched off via mode three.
  wire run1_eff = split | second_timer_run_q;
  wire open1 = run1_eff & (~gate1 | i_second_gate_pin);

  wire inc0 = tick & open0 & pulse0;
  wire inc1 = tick & open1 & pulse1;
  // split high byte counts machine cycles under the second run bit
  wire inc_split_high = tick & second_timer_run_q & split;

  // ============================================================
  // Shared counter step for modes zero to two
  // ============================================================
  // Returns {overflow, high, low}. same behaviour for both timers.
  function [16:0] step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg   [16:0] r;
    begin
      r = {1'b0, hi, lo};
      case (mode)
        // thirteen-bit count; upper three low bits left alone
        `DTEC_MODE_13BIT: begin
          r[4:0] = lo[4:0] + 5'h01;
          if (&lo[4:0]) begin
            r[15:8] = hi + 8'h01;
            r[16]   = &hi;
          end
        end
        `DTEC_MODE_16BIT: begin
          r[15:0] = {hi, lo} + 16'h0001;
          r[16]   = &{hi, lo};
        end
        // reload low byte from high byte
        `DTEC_MODE_RELOAD: begin
          if (&lo) begin
            r[7:0] = hi;
            r[16]  = 1'b1;
          end else begin
            r[7:0] = lo + 8'h01;
          end
        end
        default: begin
          r = {1'b0, hi, lo};
        end
      endcase
      step = r;
    end
  endfunction

  // ============================================================
  // Next counter values; software writes win over counting
  // ============================================================
  always @* begin
    low0_d         = low0_q;
    high0_d        = high0_q;
    low1_d         = low1_q;
    high1_d        = high1_q;
    ovf0           = 1'b0;
    ovf1           = 1'b0;
    ovf_split_high = 1'b0;
    if (split) begin
      if (inc0) begin
        low0_d = low0_q + 8'h01;
        ovf0   = &low0_q;
      end
      if (inc_split_high) begin
        high0_d        = high0_q + 8'h01;
        ovf_split_high = &high0_q;
      end
    end else if (inc0) begin
      {ovf0, high0_d, low0_d} = step(mode0, high0_q, low0_q);
    end
    // second timer stops in mode three
    if (inc1 && (mode1 != `DTEC_MODE_SPLIT)) begin
      {ovf1, high1_d, low1_d} = step(mode1, high1_q, low1_q);
    end
  end

  // split high byte takes over the second overflow flag
  wire set_flag0 = ovf0;
  wire set_flag1 = split ? ovf_split_high : ovf1;

  wire wr_rf   = i_wr & (i_addr == `DTEC_OFS_RUN_FLAG);
  wire rd_stat = i_rd & (i_addr == `DTEC_OFS_IRQ_STATUS);

  // ============================================================
  // Counter registers
  // ============================================================
  // run bit changes never clear the counts
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      low0_q  <= `DTEC_RST_BYTE;
      low1_q  <= `DTEC_RST_BYTE;
      high0_q <= `DTEC_RST_BYTE;
      high1_q <= `DTEC_RST_BYTE;
    end else begin
      low0_q  <= (i_wr && i_addr == `DTEC_OFS_LOW0)  ? i_wdata : low0_d;
      low1_q  <= (i_wr && i_addr == `DTEC_OFS_LOW1)  ? i_wdata : low1_d;
      high0_q <= (i_wr && i_addr == `DTEC_OFS_HIGH0) ? i_wdata : high0_d;
      high1_q <= (i_wr && i_addr == `DTEC_OFS_HIGH1) ? i_wdata : high1_d;
    end
  end

  // ============================================================
  // Control registers
  // ============================================================
  // Plain configuration registers written by software.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      timer_mode_control_q <= `DTEC_RST_BYTE;
      toggle_en_q          <= 2'h0;
      irq_mask_q           <= `DTEC_RST_IRQ;
      first_timer_run_q    <= 1'b0;
      second_timer_run_q   <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        `DTEC_OFS_MODE_CTRL: begin
          timer_mode_control_q <= i_wdata;
        end
        `DTEC_OFS_TOGGLE_EN: begin
          toggle_en_q <= {i_wdata[`DTEC_TG_EN1], i_wdata[`DTEC_TG_EN0]};
        end
        `DTEC_OFS_IRQ_MASK: begin
          irq_mask_q <= i_wdata[1:0];
        end
        `DTEC_OFS_RUN_FLAG: begin
          first_timer_run_q  <= i_wdata[`DTEC_RF_RUN0];
          second_timer_run_q <= i_wdata[`DTEC_RF_RUN1];
        end
        default: begin
          first_timer_run_q <= first_timer_run_q;
        end
      endcase
    end
  end

  // ============================================================
  // Overflow flags and interrupt status
  // ============================================================
  // hardware set beats a software clear in the same cycle.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      first_timer_overflow_flag_q  <= 1'b0;
      second_timer_overflow_flag_q <= 1'b0;
    end else begin
      if (set_flag0) begin
        first_timer_overflow_flag_q <= 1'b1;
      end else if (wr_rf) begin
        first_timer_overflow_flag_q <= i_wdata[`DTEC_RF_FLAG0];
      end
      if (set_flag1) begin
        second_timer_overflow_flag_q <= 1'b1;
      end else if (wr_rf) begin
        second_timer_overflow_flag_q <= i_wdata[`DTEC_RF_FLAG1];
      end
    end
  end

  // Sticky events cleared by reading; an event in the read cycle survives.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_status_q <= `DTEC_RST_IRQ;
    end else begin
      irq_status_q <= (rd_stat ? 2'h0 : irq_status_q) | {set_flag1, set_flag0};
    end
  end

  assign o_irq = |(irq_status_q & irq_mask_q);

  // ============================================================
  // Read data, valid in the cycle after the read strobe
  // ============================================================
  // Unmapped addresses read as zero.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `DTEC_OFS_RUN_FLAG: begin
          o_rdata <= {second_timer_overflow_flag_q, second_timer_run_q,
                      first_timer_overflow_flag_q, first_timer_run_q, 4'h0};
        end
        `DTEC_OFS_MODE_CTRL: begin
          o_rdata <= timer_mode_control_q;
        end
        `DTEC_OFS_LOW0: begin
          o_rdata <= low0_q;
        end
        `DTEC_OFS_LOW1: begin
          o_rdata <= low1_q;
        end
        `DTEC_OFS_HIGH0: begin
          o_rdata <= high0_q;
        end
        `DTEC_OFS_HIGH1: begin
          o_rdata <= high1_q;
        end
        `DTEC_OFS_TOGGLE_EN: begin
          o_rdata <= {6'h00, toggle_en_q};
        end
        `DTEC_OFS_IRQ_STATUS: begin
          o_rdata <= {6'h00, irq_status_q};
        end
        `DTEC_OFS_IRQ_MASK: begin
          o_rdata <= {6'h00, irq_mask_q};
        end
        default: begin
          o_rdata <= 8'h00;
        end
      endcase
    end
  end

endmodule

//--- dtec_pulse_src.sv
`timescale 1ns/10ps
// ============================================================
// External pulse source on both count pins
// ============================================================
module dtec_pulse_src (
  // Clock and pacing
  input  wire       i_clk,
  input  wire [4:0] i_half,
  // Source level
  output reg        o_level
);
  reg [4:0] cnt_q;

  initial begin
    cnt_q   = 5'h00;
    o_level = 1'b1;
  end

  // level hold
  // Each level stands i_half clocks; a zero pace parks the line high.
  always @(posedge i_clk) begin
    if (i_half == 5'h00) begin
      cnt_q   <= 5'h00;
      o_level <= 1'b1;
    end else if (cnt_q >= i_half - 5'h01) begin
      cnt_q   <= 5'h00;
      o_level <= ~o_level;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule

//--- dtec_timer_checker.sv
`timescale 1ns/10ps
// ============================================================
// Port checker for the dual timer
// ============================================================
module dtec_timer_checker (
  // Clock and reset
  input wire       i_clk,
  input wire       i_rst_n,
  // Register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  // Pins and interrupt
  input wire       o_first_count_pin,
  input wire       o_first_count_pin_oe,
  input wire       o_second_count_pin,
  input wire       o_second_count_pin_oe,
  input wire       o_irq
);
  reg [2:0] ph_q;
  reg [7:0] mode_q;
  reg [1:0] mask_q;
  reg [1:0] tg_q;

  default clocking @(posedge i_clk); endclocking

  // Mirror of the machine cycle phase and of the written control bytes.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ph_q   <= 3'h0;
      mode_q <= 8'h00;
      mask_q <= 2'h0;
      tg_q   <= 2'h0;
    end else begin
      ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
      if (i_wr && i_addr == 8'h89) mode_q <= i_wdata;
      if (i_wr && i_addr == 8'h91) mask_q <= i_wdata[1:0];
      if (i_wr && i_addr == 8'h8E) tg_q <= i_wdata[1:0];
    end
  end

  sequence rd_at(a);
    i_rd && i_addr == a;
  endsequence

  rst_quiet_a: assert property (!i_rst_n |=> !o_irq && o_rdata == 8'h00
    && !o_first_count_pin_oe && !o_second_count_pin_oe && o_first_count_pin
    && o_second_count_pin) else $error("reset state");
  mode_readback_a: assert property (disable iff (!i_rst_n)
    rd_at(8'h89) |=> o_rdata == mode_q) else $error("mode readback");
  unmapped_zero_a: assert property (disable iff (!i_rst_n)
    rd_at(8'h8F) |=> o_rdata == 8'h00) else $error("unmapped read");
  irq_masked_a: assert property (disable iff (!i_rst_n)
    mask_q == 2'h0 |-> !o_irq) else $error("masked irq");
  irq_timing_a: assert property (disable iff (!i_rst_n) $rose(o_irq) |->
    $past(ph_q) == 3'h5 || $past(ph_q, 2) == 3'h5 || $past(i_wr) || $past(i_wr, 2))
    else $error("irq off tick");
  toggle_phase_first_a: assert property (disable iff (!i_rst_n)
    $changed(o_first_count_pin) && $past(o_first_count_pin_oe) && o_first_count_pin_oe
    |-> $past(ph_q) == 3'h5) else $error("first toggle off tick");
  toggle_phase_second_a: assert property (disable iff (!i_rst_n)
    $changed(o_second_count_pin) && $past(o_second_count_pin_oe) && o_second_count_pin_oe
    |-> $past(ph_q) == 3'h5) else $error("second toggle off tick");
  pin_idle_first_a: assert property (disable iff (!i_rst_n)
    !o_first_count_pin_oe && !$past(o_first_count_pin_oe) |-> o_first_count_pin)
    else $error("first pin idle");
  pin_idle_second_a: assert property (disable iff (!i_rst_n)
    !o_second_count_pin_oe && !$past(o_second_count_pin_oe) |-> o_second_count_pin)
    else $error("second pin idle");
  oe_match_a: assert property (disable iff (!i_rst_n)
    {o_second_count_pin_oe, o_first_count_pin_oe} == tg_q) else $error("toggle enable");
endmodule

bind dtec_timer dtec_timer_checker u_chk (
  .i_clk                 (i_clk),
  .i_rst_n               (i_rst_n),
  .i_addr                (i_addr),
  .i_wdata               (i_wdata),
  .i_wr                  (i_wr),
  .i_rd                  (i_rd),
  .o_rdata               (o_rdata),
  .o_first_count_pin     (o_first_count_pin),
  .o_first_count_pin_oe  (o_first_count_pin_oe),
  .o_second_count_pin    (o_second_count_pin),
  .o_second_count_pin_oe (o_second_count_pin_oe),
  .o_irq                 (o_irq)
);

//--- dtec_timer_tb.sv
`timescale 1ns/10ps
// ============================================================
// Self-checking bench for the dual timer
// ============================================================
module dtec_timer_tb;
  reg         i_clk = 1'b0;
  reg         i_rst_n = 1'b0;
  reg  [7:0]  i_addr = 8'h00;
  reg  [7:0]  i_wdata = 8'h00;
  reg         i_wr = 1'b0;
  reg         i_rd = 1'b0;
  reg         gate = 1'b0;
  reg  [4:0]  half = 5'h00;
  wire [7:0]  o_rdata;
  wire        p0_o, p0_oe, p1_o, p1_oe, o_irq, src;
  wire        pin0 = p0_oe ? p0_o : src;
  wire        pin1 = p1_oe ? p1_o : src;
  integer     failures = 0;
  integer     check_count = 0;
  integer     cycles = 0;
  integer     i;
  reg  [7:0]  v0, v1, a;
  reg         tg;
  reg  [22:0] rows [0:7];

  dtec_timer u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_first_count_pin(pin0), .o_first_count_pin(p0_o),
    .o_first_count_pin_oe(p0_oe), .i_first_gate_pin(gate),
    .i_second_count_pin(pin1), .o_second_count_pin(p1_o),
    .o_second_count_pin_oe(p1_oe), .i_second_gate_pin(gate), .o_irq(o_irq));

  dtec_pulse_src u_src (.i_clk(i_clk), .i_half(half), .o_level(src));

  // Clock of 25 ns and a cycle ceiling well above the planned run.
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures = failures + 1;
      final_report;
    end
  end

  task wr(input [7:0] ad, input [7:0] d);
    begin
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= ad;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
    end
  endtask

  // Read data is taken in the single cycle after the strobe.
  task rd(input [7:0] ad, output [7:0] d);
    begin
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= ad;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      d = o_rdata;
    end
  endtask

  task chk(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // Two reads of one byte exactly 120 clocks apart. The pulse source is given one
  // slow period to settle first, so that a pace change cannot add a stray edge.
  task delta(input [7:0] ad, output [7:0] d);
    begin
      repeat (24) @(posedge i_clk);
      rd(ad, v0);
      repeat (118) @(posedge i_clk);
      rd(ad, v1);
      d = v1 - v0;
    end
  endtask

  // Preload, run timer 0 for five machine cycles, check the overflow.
  task ovf(input [7:0] mc, input [7:0] hi, input [7:0] lo, input [7:0] ehi,
           input [7:0] lmask, input [7:0] elo);
    begin
      wr(8'h88, 8'h00);
      wr(8'h89, mc);
      wr(8'h8C, hi);
      wr(8'h8A, lo);
      wr(8'h88, 8'h10);
      repeat (30) @(negedge i_clk);
      tg = ~tg;
      chk({7'h00, o_irq}, 8'h01);
      chk({7'h00, pin0}, {7'h00, tg});
      rd(8'h88, v0);
      chk(v0 & 8'h20, 8'h20);
      rd(8'h8C, v0);
      chk(v0, ehi);
      rd(8'h8A, v0);
      chk(v0 & lmask, elo);
      rd(8'h90, v0);
      chk(v0, 8'h01);
      chk({7'h00, o_irq}, 8'h00);
    end
  endtask

  task final_report;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // Rows: mode byte, timer, gate level, source half period, low byte delta.
  initial begin
    rows[0] = {8'h01, 1'h0, 1'h0, 5'h00, 8'h14};
    rows[1] = {8'h05, 1'h0, 1'h0, 5'h06, 8'h0A};
    rows[2] = {8'h05, 1'h0, 1'h0, 5'h0C, 8'h05};
    rows[3] = {8'h05, 1'h0, 1'h0, 5'h00, 8'h00};
    rows[4] = {8'h09, 1'h0, 1'h0, 5'h00, 8'h00};
    rows[5] = {8'h09, 1'h0, 1'h1, 5'h00, 8'h14};
    rows[6] = {8'h50, 1'h1, 1'h0, 5'h0C, 8'h05};
    rows[7] = {8'h90, 1'h1, 1'h0, 5'h00, 8'h00};
    tg = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wr(8'h8F, 8'hFF);
    for (a = 8'h88; a <= 8'h91; a = a + 8'h01) begin
      rd(a, v0);
      chk(v0, 8'h00);
    end
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h88, 8'h00);
      wr(8'h89, rows[i][22:15]);
      gate <= rows[i][13];
      half <= rows[i][12:8];
      rd(8'h89, v0);
      chk(v0, rows[i][22:15]);
      wr(8'h88, rows[i][14] ? 8'h40 : 8'h10);
      delta(8'h8A + {7'h00, rows[i][14]}, v1);
      chk(v1, rows[i][7:0]);
    end
    half <= 5'h00;
    wr(8'h91, 8'h01);
    wr(8'h8E, 8'h01);
    ovf(8'h00, 8'hFF, 8'hFE, 8'h00, 8'hE0, 8'hE0);
    ovf(8'h01, 8'hFF, 8'hFE, 8'h00, 8'h00, 8'h00);
    ovf(8'h02, 8'h80, 8'hFE, 8'h80, 8'h80, 8'h80);
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h33);
    wr(8'h8B, 8'h55);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'h11);
    wr(8'h88, 8'h40);
    repeat (30) @(negedge i_clk);
    rd(8'h88, v0);
    chk(v0 & 8'hA0, 8'h80);
    rd(8'h8B, v0);
    chk(v0, 8'h55);
    rd(8'h8A, v0);
    chk(v0, 8'h11);
    rd(8'h90, v0);
    chk(v0, 8'h02);
    // Second timer in reload mode with its toggle output on.
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h20);
    wr(8'h8B, 8'hFE);
    wr(8'h8E, 8'h03);
    wr(8'h88, 8'h40);
    repeat (30) @(negedge i_clk);
    chk({6'h00, p1_oe, p1_o}, 8'h02);
    rd(8'h88, v0);
    chk(v0 & 8'hA0, 8'h80);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(8'h89, v0);
    chk(v0, 8'h00);
    chk({3'h0, p1_oe, p1_o, p0_oe, o_irq, p0_o}, 8'h09);
    final_report;
  end
endmodule
